// ===== bench/pwt_pin_probe.sv
/*
  Pin probe: external load on the waveform pin that measures widths.
  Assumes the pin is sampled on the rising edge of the timer clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pwt_pin_probe (
  input  wire logic        i_clk,
  input  wire logic        i_pin,
  output logic      [15:0] o_hi_w,
  output logic      [15:0] o_lo_w,
  output logic      [15:0] o_edges
);
  logic        last_reg = 1'h0;
  logic [15:0] run_reg  = 16'h0000;

  initial begin
    o_hi_w  = 16'h0000;
    o_lo_w  = 16'h0000;
    o_edges = 16'h0000;
  end

  // Each level change closes a width measured in clock cycles.
  always @(posedge i_clk) begin
    if (i_pin !== last_reg) begin
      if (last_reg === 1'h1) begin
        o_hi_w = run_reg;
      end else begin
        o_lo_w = run_reg;
      end
      o_edges  = o_edges + 16'h0001;
      run_reg  = 16'h0001;
      last_reg = i_pin;
    end else begin
      run_reg = run_reg + 16'h0001;
    end
  end
endmodule : pwt_pin_probe

`default_nettype wire

// ===== bench/tb.sv
/*
  Self-checking bench of the programmable waveform timer.
  Assumes the timer package, the timer and the pin probe are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  typedef struct {
    pwt_pkg::pwt_src_t s;
    logic [7:0]        n;
    logic [7:0]        m;
    logic [7:0]        p;
    logic              l;
    int                d;
  } pwt_row_t;

  logic              clk    = 1'h0;
  logic              resetn = 1'h0;
  logic              run    = 1'h0;
  logic              halt   = 1'h0;
  logic              comp   = 1'h0;
  logic              p3     = 1'h0;
  logic              p1     = 1'h0;
  logic              ext    = 1'h0;
  pwt_pkg::pwt_cfg_t cfg    = '0;
  pwt_pkg::pwt_wr_t  wrs    = '0;
  logic [7:0]        pre_cnt;
  logic [7:0]        pri_cnt;
  logic              counting, irq, pin3, pin1, ext_o;
  logic [15:0]       hi_w, lo_w, edges;
  int                fails = 0, tests_run = 0, irq_n = 0, cdiv = 0;
  pwt_row_t          rows[5] = '{
    '{pwt_pkg::PWT_SRC_F1,   8'h00, 8'h01, 8'h00, 1'h0, 1},
    '{pwt_pkg::PWT_SRC_F2,   8'h01, 8'h02, 8'h03, 1'h1, 2},
    '{pwt_pkg::PWT_SRC_F8,   8'h00, 8'h00, 8'h01, 1'h0, 8},
    '{pwt_pkg::PWT_SRC_COMP, 8'h02, 8'h01, 8'h00, 1'h1, 3},
    '{pwt_pkg::PWT_SRC_F1,   8'h00, 8'hFF, 8'h00, 1'h0, 1}};

  always #12.5 clk = ~clk;

  // Companion underflow: one pulse every third clock.
  always @(negedge clk) begin
    cdiv <= (cdiv == 2) ? 0 : cdiv + 1;
    comp <= (cdiv == 2);
  end

  pwt_timer dut_u (.i_clk(clk), .i_resetn(resetn), .i_run_bit(run), .i_force_halt_bit(halt),
    .i_cfg(cfg), .i_wr(wrs), .i_companion_uf(comp), .i_port3_latch(p3), .i_port1_latch(p1),
    .i_ext_irq_in(ext), .o_prescale_cnt(pre_cnt), .o_primary_cnt(pri_cnt),
    .o_counting(counting), .o_irq(irq), .o_port3_line1(pin3), .o_port1_line3(pin1),
    .o_ext_irq(ext_o));

  pwt_pin_probe probe_u (.i_clk(clk), .i_pin(pin3), .o_hi_w(hi_w), .o_lo_w(lo_w),
    .o_edges(edges));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic write_reg(input int k, input logic [7:0] d);
    wrs.prescale  = (k == 0);
    wrs.primary   = (k == 1);
    wrs.secondary = (k == 2);
    wrs.data      = d;
    tick(1);
    wrs = '0;
    tick(1);
  endtask : write_reg

  task automatic wait_edges(input int n);
    int e0;
    e0 = edges;
    for (int k = 0; k < 5000 && int'(edges) - e0 < n; k++) @(negedge clk);
    if (int'(edges) - e0 < n) begin
      fails++;
      give_verdict();
    end
  endtask : wait_edges

  task automatic load(input pwt_row_t r);
    run = 1'h0;
    tick(2);
    cfg.cnt_src_sel   = r.s;
    cfg.out_level_sel = r.l;
    write_reg(0, r.n);
    write_reg(1, r.m);
    write_reg(2, r.p);
    check("pre_cnt", pre_cnt, 16'(r.n));
    check("pri_cnt", pri_cnt, 16'(r.m));
    check("idle_pin", pin3, 16'(r.l));
  endtask : load

  // Interrupt pulses coincide with the return to the primary level.
  always @(negedge clk) begin
    if (irq === 1'h1 && !cfg.out_pin_loc_sel && !cfg.out_source_sel) begin
      irq_n++;
      check("irq_pin", pin3, {15'h0000, ~cfg.out_level_sel});
    end
  end

  initial begin
    int pri, sec, k;
    logic v;
    tick(5);
    resetn = 1'h1;
    tick(1);
    check("rst_counting", counting, 16'h0000);
    check("rst_pri", pri_cnt, 16'h00FF);
    check("rst_pin", pin3, 16'h0000);
    foreach (rows[i]) begin
      load(rows[i]);
      pri = (rows[i].n + 1) * (rows[i].m + 1) * rows[i].d;
      sec = (rows[i].n + 1) * (rows[i].p + 1) * rows[i].d;
      run = 1'h1;
      tick(1);
      check("start", counting, 16'h0001);
      check("first_pin", pin3, {15'h0000, ~rows[i].l});
      wait_edges(5);
      check("hi_w", hi_w, 16'(rows[i].l ? sec : pri));
      check("lo_w", lo_w, 16'(rows[i].l ? pri : sec));
    end
    load('{pwt_pkg::PWT_SRC_F1, 8'h01, 8'h03, 8'h01, 1'h0, 1});
    run = 1'h1;
    wait_edges(3);
    // The write lands on a cycle without a prescaler underflow.
    tick(1);
    write_reg(1, 8'h09);
    check("run_write", 16'(pri_cnt <= 8'h03), 16'h0001);
    wait_edges(6);
    check("new_hi", hi_w, 16'h0014);
    check("old_lo", lo_w, 16'h0004);
    halt = 1'h1;
    tick(1);
    halt = 1'h0;
    tick(2);
    check("halted", counting, 16'h0000);
    tick(3);
    check("refused", counting, 16'h0000);
    run = 1'h0;
    tick(1);
    run = 1'h1;
    tick(2);
    check("restart", counting, 16'h0001);
    run = 1'h0;
    tick(2);
    check("stopped", counting, 16'h0000);
    v = pri_cnt[0];
    tick(4);
    check("hold", pri_cnt[0], 16'(v));
    load('{pwt_pkg::PWT_SRC_F1, 8'h00, 8'hFF, 8'hFF, 1'h1, 1});
    cfg.out_source_sel = 1'h1;
    p3 = 1'h1;
    run = 1'h1;
    tick(3);
    check("latch_out", pin3, 16'h0001);
    cfg.out_source_sel = 1'h0;
    tick(10);
    check("src_held", pin3, 16'h0001);
    wait_edges(2);
    check("src_wave", lo_w, 16'h0100);
    p3 = 1'h0;
    load('{pwt_pkg::PWT_SRC_F1, 8'h00, 8'h01, 8'h00, 1'h0, 1});
    cfg.out_pin_loc_sel = 1'h1;
    p3 = 1'h1;
    run = 1'h1;
    v = pin1;
    k = 0;
    repeat (20) begin
      tick(1);
      if (pin1 !== v) k++;
      v = pin1;
    end
    check("loc_latch", pin3, 16'h0001);
    check("loc_wave", 16'(k != 0), 16'h0001);
    run = 1'h0;
    ext = 1'h1;
    tick(4);
    check("ext_sync", ext_o, 16'h0001);
    check("ext_no_run", counting, 16'h0000);
    check("irq_seen", 16'(irq_n != 0), 16'h0001);
    give_verdict();
  end
endmodule : tb

`default_nettype wire

// ===== logic/pwt_pkg.sv
/*
  Shared constants and types of the programmable waveform timer.
  Assumes one 40 MHz clock domain and no register bus; the package is
  referenced by full scoped names only.
*/
`default_nettype none

package pwt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths, reset values and timing counts.

  localparam int unsigned CNT_W      = 8;
  localparam logic [7:0]  RELOAD_RST = 8'hFF;
  localparam logic [7:0]  CNT_ONE    = 8'h01;
  localparam logic [7:0]  CNT_ZERO   = 8'h00;
  localparam logic [2:0]  DIV_RST    = 3'h0;
  localparam logic [2:0]  DIV_ONE    = 3'h1;
  localparam logic [2:0]  DIV8_LAST  = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations.

  typedef enum logic [1:0] {
    PWT_SRC_F1   = 2'h0,
    PWT_SRC_F2   = 2'h1,
    PWT_SRC_F8   = 2'h2,
    PWT_SRC_COMP = 2'h3
  } pwt_src_t;

  typedef enum logic {
    PWT_PRIMARY   = 1'b0,
    PWT_SECONDARY = 1'b1
  } pwt_phase_t;

  typedef enum logic {
    PWT_IDLE = 1'b0,
    PWT_RUN  = 1'b1
  } pwt_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.

  typedef struct packed {
    logic     out_level_sel;
    logic     out_source_sel;
    logic     out_pin_loc_sel;
    pwt_src_t cnt_src_sel;
  } pwt_cfg_t;

  typedef struct packed {
    logic             prescale;
    logic             primary;
    logic             secondary;
    logic [CNT_W-1:0] data;
  } pwt_wr_t;

endpackage : pwt_pkg

`default_nettype wire

// ===== logic/pwt_timer.sv
/*
  Programmable waveform timer: prescaler, alternating main counter and
  waveform pin driver.
  Assumes control bits and write strobes come from logic on i_clk; only
  the external interrupt pin is asynchronous.
*/
// What this block does
// R1: Each underflow inverts output and swaps period.
// R2: Primary period is counted first after start.
// R3: One-shot control register is ignored here.
// R4: Count source is f1, f2, f8 or companion.
// R5: Decrement; reload primary and secondary alternately.
// R6: Primary phase lasts (n+1)(m+1) source cycles.
// R7: Secondary phase lasts (n+1)(p+1) source cycles.
// R8: Writing run bit one starts counting.
// R9: Writing run bit zero stops counting.
// R10: Writing force-halt one forcibly stops counting.
// R11: Interrupt with pin change after secondary underflow.
// R12: Live prescaler and primary counts are readable.
// R13: Stopped writes load reload register and counter.
// R14: Running writes load only the reload register.
// R15: Running writes apply from the next primary; here only once a running primary write is made.
// R16: Level select sets primary and secondary levels.
// R17: Source select picks waveform or port latch.
// R18: Source select taken at start or interrupt.
// R19: Pin-location select picks the output pin.
// R20: External interrupt pin never triggers the timer.
// R21: Reloads follow source ticks and prescaler underflows.
// R22: After reset stopped, pin at inactive level.
`timescale 1ns/1ps
`default_nettype none

module pwt_timer (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_run_bit,
  input  wire logic             i_force_halt_bit,
  input  wire pwt_pkg::pwt_cfg_t i_cfg,
  input  wire pwt_pkg::pwt_wr_t  i_wr,
  input  wire logic             i_companion_uf,
  input  wire logic             i_port3_latch,
  input  wire logic             i_port1_latch,
  input  wire logic             i_ext_irq_in,
  output logic [7:0]            o_prescale_cnt,
  output logic [7:0]            o_primary_cnt,
  output logic                  o_counting,
  output logic                  o_irq,
  output logic                  o_port3_line1,
  output logic                  o_port1_line3,
  output logic                  o_ext_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  pwt_pkg::pwt_state_t state_reg;
  pwt_pkg::pwt_state_t state_next;
  pwt_pkg::pwt_phase_t phase_reg;
  pwt_pkg::pwt_phase_t phase_next;
  logic                halt_reg;
  logic                halt_next;
  logic [2:0]          div_reg;
  logic [7:0]          pre_cnt_reg;
  logic [7:0]          pre_cnt_next;
  logic [7:0]          main_cnt_reg;
  logic [7:0]          main_cnt_next;
  logic [7:0]          pre_rld_reg;
  logic [7:0]          pri_rld_reg;
  logic [7:0]          sec_rld_reg;
  logic [7:0]          pend_pre_reg;
  logic [7:0]          pend_pri_reg;
  logic [7:0]          pend_sec_reg;
  logic                pend_flag_reg;
  logic                src_sel_reg;
  logic                src_sel_next;
  logic                irq_reg;
  logic                pin3_reg;
  logic                pin1_reg;
  logic                ext_s1_reg;
  logic                ext_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Run control.

  wire run_req  = i_run_bit & ~halt_reg & ~i_force_halt_bit;  // R3 R8 R10
  wire counting = (state_reg == pwt_pkg::PWT_RUN);
  wire start    = run_req & ~counting;

  always_comb begin
    state_next = run_req ? pwt_pkg::PWT_RUN : pwt_pkg::PWT_IDLE;  // R8 R9 R10
    halt_next  = halt_reg;
    if (i_force_halt_bit) begin
      halt_next = 1'b1;  // R10
    end else if (!i_run_bit) begin
      halt_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count source selection.

  wire src_f1   = (i_cfg.cnt_src_sel == pwt_pkg::PWT_SRC_F1);
  wire src_f2   = (i_cfg.cnt_src_sel == pwt_pkg::PWT_SRC_F2) & div_reg[0];
  wire src_f8   = (i_cfg.cnt_src_sel == pwt_pkg::PWT_SRC_F8) &
                  (div_reg == pwt_pkg::DIV8_LAST);
  wire src_comp = (i_cfg.cnt_src_sel == pwt_pkg::PWT_SRC_COMP) & i_companion_uf;
  wire tick     = counting & (src_f1 | src_f2 | src_f8 | src_comp);  // R4

  ////////////////////////////////////////////////////////////////////////////
  // Underflow decode.

  wire pre_uf   = tick & (pre_cnt_reg == pwt_pkg::CNT_ZERO);  // R21
  wire main_uf  = pre_uf & (main_cnt_reg == pwt_pkg::CNT_ZERO);
  wire sec_end  = main_uf & (phase_reg == pwt_pkg::PWT_SECONDARY);
  wire use_pend = sec_end & pend_flag_reg;  // R15

  wire [7:0] pre_rld_eff = use_pend ? pend_pre_reg : pre_rld_reg;
  wire [7:0] pri_rld_eff = use_pend ? pend_pri_reg : pri_rld_reg;
  wire [7:0] sec_rld_eff = use_pend ? pend_sec_reg : sec_rld_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Counter next values.

  always_comb begin
    pre_cnt_next = pre_cnt_reg;
    if (start) begin
      pre_cnt_next = pre_rld_reg;
    end else if (!counting && i_wr.prescale) begin
      pre_cnt_next = i_wr.data;  // R13
    end else if (pre_uf) begin
      pre_cnt_next = pre_rld_eff;  // R21
    end else if (tick) begin
      pre_cnt_next = pre_cnt_reg - pwt_pkg::CNT_ONE;  // R5 R6 R7
    end
  end

  always_comb begin
    main_cnt_next = main_cnt_reg;
    phase_next    = phase_reg;
    if (start) begin
      main_cnt_next = pri_rld_reg;  // R2
      phase_next    = pwt_pkg::PWT_PRIMARY;  // R2
    end else if (!counting && i_wr.primary) begin
      main_cnt_next = i_wr.data;  // R13
    end else if (main_uf) begin
      if (phase_reg == pwt_pkg::PWT_PRIMARY) begin
        main_cnt_next = sec_rld_reg;  // R5 R7
        phase_next    = pwt_pkg::PWT_SECONDARY;  // R1
      end else begin
        main_cnt_next = pri_rld_eff;  // R5 R6
        phase_next    = pwt_pkg::PWT_PRIMARY;  // R1
      end
    end else if (pre_uf) begin
      main_cnt_next = main_cnt_reg - pwt_pkg::CNT_ONE;  // R5 R21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive.

  wire run_next = (state_next == pwt_pkg::PWT_RUN);
  wire pri_next = run_next & (phase_next == pwt_pkg::PWT_PRIMARY);
  wire wave     = pri_next ? ~i_cfg.out_level_sel : i_cfg.out_level_sel;  // R16 R22

  always_comb begin
    src_sel_next = src_sel_reg;
    if (start || sec_end) begin
      src_sel_next = i_cfg.out_source_sel;  // R18
    end
  end

  wire latch_sel = i_cfg.out_pin_loc_sel ? i_port1_latch : i_port3_latch;
  wire drive     = src_sel_next ? latch_sel : wave;  // R17
  wire pin3_next = i_cfg.out_pin_loc_sel ? i_port3_latch : drive;  // R19
  wire pin1_next = i_cfg.out_pin_loc_sel ? drive : i_port1_latch;  // R19

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_reg    <= pwt_pkg::PWT_IDLE;  // R22
      phase_reg    <= pwt_pkg::PWT_PRIMARY;
      halt_reg     <= 1'b0;
      div_reg      <= pwt_pkg::DIV_RST;
      pre_cnt_reg  <= pwt_pkg::RELOAD_RST;
      main_cnt_reg <= pwt_pkg::RELOAD_RST;
      src_sel_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      phase_reg    <= phase_next;
      halt_reg     <= halt_next;
      div_reg      <= div_reg + pwt_pkg::DIV_ONE;
      pre_cnt_reg  <= pre_cnt_next;
      main_cnt_reg <= main_cnt_next;
      src_sel_reg  <= src_sel_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pre_rld_reg   <= pwt_pkg::RELOAD_RST;
      pri_rld_reg   <= pwt_pkg::RELOAD_RST;
      sec_rld_reg   <= pwt_pkg::RELOAD_RST;
      pend_pre_reg  <= pwt_pkg::RELOAD_RST;
      pend_pri_reg  <= pwt_pkg::RELOAD_RST;
      pend_sec_reg  <= pwt_pkg::RELOAD_RST;
      pend_flag_reg <= 1'b0;
    end else begin
      if (i_wr.prescale) begin
        pend_pre_reg <= i_wr.data;  // R14
      end
      if (i_wr.primary) begin
        pend_pri_reg <= i_wr.data;  // R14
      end
      if (i_wr.secondary) begin
        pend_sec_reg <= i_wr.data;  // R14
      end
      if (!counting) begin
        if (i_wr.prescale) begin
          pre_rld_reg <= i_wr.data;  // R13
        end
        if (i_wr.primary) begin
          pri_rld_reg <= i_wr.data;  // R13
        end
        if (i_wr.secondary) begin
          sec_rld_reg <= i_wr.data;  // R13
        end
      end else if (use_pend) begin
        pre_rld_reg <= pre_rld_eff;  // R15
        pri_rld_reg <= pri_rld_eff;  // R15
        sec_rld_reg <= sec_rld_eff;  // R15
      end
      pend_flag_reg <= (counting & i_wr.primary) | (pend_flag_reg & ~use_pend & counting);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      irq_reg    <= 1'b0;
      pin3_reg   <= 1'b0;
      pin1_reg   <= 1'b0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
    end else begin
      irq_reg    <= sec_end;  // R11
      pin3_reg   <= pin3_next;
      pin1_reg   <= pin1_next;
      ext_s1_reg <= i_ext_irq_in;  // R20
      ext_s2_reg <= ext_s1_reg;
    end
  end

  assign o_prescale_cnt = pre_cnt_reg;  // R12
  assign o_primary_cnt  = main_cnt_reg;  // R12
  assign o_counting     = counting;
  assign o_irq          = irq_reg;
  assign o_port3_line1  = pin3_reg;
  assign o_port1_line3  = pin1_reg;
  assign o_ext_irq      = ext_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_phase_swap: assert property (  // R1
    @(posedge i_clk) disable iff (!i_resetn)
    (main_uf && !start) |=> (phase_reg != $past(phase_reg)))
    else $error("Phase did not swap on underflow.");

  chk_start_primary: assert property (  // R2
    @(posedge i_clk) disable iff (!i_resetn)
    start |=> (phase_reg == pwt_pkg::PWT_PRIMARY) && counting)
    else $error("Start did not begin in the primary period.");

  chk_count_down: assert property (  // R5
    @(posedge i_clk) disable iff (!i_resetn)
    (pre_uf && !main_uf && !start) |=> (main_cnt_reg == $past(main_cnt_reg) - 8'h01))
    else $error("Main counter did not decrement on prescaler underflow.");

  chk_stop_hold: assert property (  // R9
    @(posedge i_clk) disable iff (!i_resetn)
    (!counting && !run_req && !i_wr.primary) |=> $stable(main_cnt_reg))
    else $error("Main counter moved while stopped.");

  chk_halt_stop: assert property (  // R10
    @(posedge i_clk) disable iff (!i_resetn)
    (i_force_halt_bit && i_run_bit) |=> !counting ##1 (!counting || !$past(i_run_bit)))
    else $error("Force halt did not stop counting.");

  chk_irq_cause: assert property (  // R11
    @(posedge i_clk) disable iff (!i_resetn)
    o_irq |-> $past(main_uf) && ($past(phase_reg) == pwt_pkg::PWT_SECONDARY))
    else $error("Interrupt without a secondary underflow.");

  chk_irq_with_pin: assert property (  // R11
    @(posedge i_clk) disable iff (!i_resetn)
    (sec_end && !i_cfg.out_source_sel && run_req) |=> o_irq && (phase_reg == pwt_pkg::PWT_PRIMARY))
    else $error("Interrupt not raised with the primary output change.");

  chk_idle_write: assert property (  // R13
    @(posedge i_clk) disable iff (!i_resetn)
    (!counting && !run_req && i_wr.primary) |=> (main_cnt_reg == $past(i_wr.data)))
    else $error("Stopped write did not load the counter.");

  chk_run_write: assert property (  // R14
    @(posedge i_clk) disable iff (!i_resetn)
    (counting && run_req && i_wr.primary && !pre_uf) |=> $stable(main_cnt_reg))
    else $error("Running write disturbed the counter.");

endmodule : pwt_timer

`default_nettype wire
